// File: verilog/rlrx_exec.sv
// rlrx_exec: executes the return-with-literal, plain return and the two
// rotate-through-carry opcodes of an 8-bit core.
// assumes the fetch path presents one word per cycle with insn_valid, and
// the register file returns the addressed byte combinationally in file_rdata.
//
// How it works
// - return-with-literal loads literal into working reg
// - return-with-literal loads pc from stack top
// - return-with-literal is one word, two cycles
// - rotate left: old carry in, bit7 out
// - rotate left: dest 0 to w, 1 to file
// - rotate left: 7-bit address, single cycle
// - rotate right: old carry in bit7, bit0 out
// - rotate right: address 0..127, dest 0 to w
// - plain return pops stack into pc, two cycles
`timescale 1ns/100ps
module rlrx_exec #(
   parameter int DEPTH = 16
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic insn_valid,
   input wire logic [13:0] insn_word,
   input wire logic [7:0] file_rdata,
   input wire logic [14:0] stack_top,
   output logic [6:0] file_addr,
   output logic [7:0] file_wdata,
   output logic file_we,
   output logic [7:0] w_out,
   output logic carry_out,
   output logic [14:0] pc_out,
   output logic pc_load,
   output logic stack_pop,
   output logic flush,
   output logic busy
);
   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      RLRX_OP_NONE = 2'b00,
      RLRX_OP_RET = 2'b01,
      RLRX_OP_ROTL = 2'b10,
      RLRX_OP_ROTR = 2'b11
   } rlrx_kind_t;

   // classify a word; used for decode only, is_retlit does the literal check
   function automatic rlrx_kind_t rlrx_classify(input logic [13:0] w);
      rlrx_kind_t k;
      k = RLRX_OP_NONE;
      if (w == rlrx_pkg::OP_RETURN ||
          w[13:10] == rlrx_pkg::OP_RETLIT_HI)
         k = RLRX_OP_RET;
      else if (w[13:8] == rlrx_pkg::OP_ROTL)
         k = RLRX_OP_ROTL;
      else if (w[13:8] == rlrx_pkg::OP_ROTR)
         k = RLRX_OP_ROTR;
      return k;
   endfunction : rlrx_classify

   logic [7:0] w_reg;
   logic carry_reg;
   logic [14:0] pc_reg;
   logic pc_load_reg;
   logic pop_reg;
   logic flush_reg;
   logic busy_reg;
   logic [6:0] addr_reg;
   logic [7:0] wdata_reg;
   logic we_reg;
   localparam int DEPTH_W = $clog2(DEPTH+1);
   logic [DEPTH_W-1:0] depth_reg;
   rlrx_kind_t kind;
   logic is_retlit;
   logic accept;
   logic [7:0] rot_val;
   logic rot_carry;
   logic [7:0] rot_src;

   ////////////////////////////////////////////////////////////////////////
   // decode; second cycle of a return swallows the flushed fetch
   assign kind = rlrx_classify(insn_word);
   assign is_retlit = insn_word[13:10] == rlrx_pkg::OP_RETLIT_HI;
   assign accept = clk_en && insn_valid && !busy_reg;
   assign file_addr = insn_word[6:0];
   // write-back lands one edge late, so a rotate behind another on
   // the same address would read the stale byte; take the pending value
   assign rot_src = (we_reg && addr_reg == insn_word[6:0]) ? wdata_reg :
      file_rdata;
   // combinational rotate through carry
   always_comb begin
      rot_val = {rot_src[6:0], carry_reg};
      rot_carry = rot_src[7];
      if (kind == RLRX_OP_ROTR) begin
         rot_val = {carry_reg, rot_src[7:1]};
         rot_carry = rot_src[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // working register and carry; rotates finish in one cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         w_reg <= rlrx_pkg::W_RESET;
         carry_reg <= rlrx_pkg::CARRY_RESET;
      end else if (accept) begin
         if (kind == RLRX_OP_RET && is_retlit)
            w_reg <= insn_word[7:0];
         if (kind == RLRX_OP_ROTL || kind == RLRX_OP_ROTR) begin
            carry_reg <= rot_carry;
            if (!insn_word[rlrx_pkg::DEST_BIT])
               w_reg <= rot_val;
         end
      end
   end

   // file write back only when dest is 1
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         we_reg <= 1'b0;
         addr_reg <= 7'h00;
         wdata_reg <= 8'h00;
      end else if (clk_en) begin
         we_reg <= accept && (kind == RLRX_OP_ROTL || kind == RLRX_OP_ROTR)
            && insn_word[rlrx_pkg::DEST_BIT];
         addr_reg <= insn_word[6:0];
         wdata_reg <= rot_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // returns: pc from stack top, pop, flush, one busy cycle
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pc_reg <= rlrx_pkg::PC_RESET;
         pc_load_reg <= 1'b0;
         pop_reg <= 1'b0;
         flush_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else if (clk_en) begin
         pc_load_reg <= 1'b0;
         pop_reg <= 1'b0;
         flush_reg <= 1'b0;
         busy_reg <= 1'b0;
         if (accept && kind == RLRX_OP_RET) begin
            pc_reg <= stack_top;
            pc_load_reg <= 1'b1;
            pop_reg <= 1'b1;
            flush_reg <= 1'b1;
            busy_reg <= 1'b1;
         end
      end
   end

   // pointer depth kept for visibility of unwinding; pop after read
   always_ff @(posedge clock) begin
      if (!rst_b)
         depth_reg <= DEPTH_W'(DEPTH); // full stack after reset
      else if (clk_en && pop_reg && depth_reg != '0)
         depth_reg <= depth_reg - 1'b1;
   end

   assign file_wdata = wdata_reg;
   assign file_we = we_reg;
   assign w_out = w_reg;
   assign carry_out = carry_reg;
   assign pc_out = pc_reg;
   assign pc_load = pc_load_reg;
   assign stack_pop = pop_reg;
   assign flush = flush_reg;
   assign busy = busy_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_retlit_w;
      @(posedge clock) disable iff (!rst_b)
      accept && kind == RLRX_OP_RET && is_retlit |=>
         w_reg == $past(insn_word[7:0]);
   endproperty
   a_retlit_w: assert property (p_retlit_w)
      else $error("literal not loaded");
   property p_ret_pc;
      @(posedge clock) disable iff (!rst_b)
      accept && kind == RLRX_OP_RET |=>
         pc_load && pc_out == $past(stack_top) && stack_pop;
   endproperty
   a_ret_pc: assert property (p_ret_pc)
      else $error("pc not loaded from stack top");
   property p_ret_two;
      @(posedge clock) disable iff (!rst_b)
      accept && kind == RLRX_OP_RET |=> busy && flush;
   endproperty
   a_ret_two: assert property (p_ret_two)
      else $error("return not two cycles");
   property p_rotl;
      @(posedge clock) disable iff (!rst_b)
      accept && kind == RLRX_OP_ROTL && !insn_word[7] |=>
         w_out == {$past(rot_src[6:0]), $past(carry_reg)} &&
         carry_out == $past(rot_src[7]);
   endproperty
   a_rotl: assert property (p_rotl)
      else $error("rotate left wrong");
   property p_rotr;
      @(posedge clock) disable iff (!rst_b)
      accept && kind == RLRX_OP_ROTR && !insn_word[7] |=>
         w_out == {$past(carry_reg), $past(rot_src[7:1])} &&
         carry_out == $past(rot_src[0]);
   endproperty
   a_rotr: assert property (p_rotr)
      else $error("rotate right wrong");
   property p_dest_file;
      @(posedge clock) disable iff (!rst_b)
      clk_en && accept && kind != RLRX_OP_NONE && kind != RLRX_OP_RET &&
         insn_word[7] |=> file_we && w_out == $past(w_reg);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("dest file path wrong");
   property p_no_we;
      @(posedge clock) disable iff (!rst_b)
      clk_en && !(accept && insn_word[7]) |=> !file_we;
   endproperty
   a_no_we: assert property (p_no_we)
      else $error("spurious file write");
   property p_rot_single;
      @(posedge clock) disable iff (!rst_b)
      accept && (kind == RLRX_OP_ROTL || kind == RLRX_OP_ROTR) |=> !busy;
   endproperty
   a_rot_single: assert property (p_rot_single)
      else $error("rotate stalled");
   property p_depth_pop;
      @(posedge clock) disable iff (!rst_b)
      clk_en && stack_pop && depth_reg != '0 |=>
         depth_reg == $past(depth_reg) - 1'b1;
   endproperty
   a_depth_pop: assert property (p_depth_pop)
      else $error("stack depth not unwound");
   c_retlit: cover property (@(posedge clock)
      accept && kind == RLRX_OP_RET && is_retlit);
   c_rotl_file: cover property (@(posedge clock)
      accept && kind == RLRX_OP_ROTL && insn_word[7]);
   c_rotr_w: cover property (@(posedge clock)
      accept && kind == RLRX_OP_ROTR && !insn_word[7]);
endmodule : rlrx_exec

// File: verilog/rlrx_pkg.sv
// rlrx_pkg: opcodes, field layout and reset values for the rotate and
// return execution block.
// assumes a 14-bit program word and a 15-bit program counter.
package rlrx_pkg;
   localparam int WORD_W = 14;
   localparam int PC_W = 15;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   // opcode fields of the 14-bit word
   localparam logic [13:0] OP_RETURN = 14'h0008;
   localparam logic [3:0] OP_RETLIT_HI = 4'hd; // word[13:10] = 11_01
   localparam logic [5:0] OP_ROTL = 6'h0d;      // word[13:8] = 00_1101
   localparam logic [5:0] OP_ROTR = 6'h0c;      // word[13:8] = 00_1100
   localparam int DEST_BIT = 7;
   localparam logic [7:0] W_RESET = 8'h00;
   localparam logic [14:0] PC_RESET = 15'h0000;
   localparam logic CARRY_RESET = 1'b0;
   localparam logic [1:0] RET_CYCLES = 2'h2;
endpackage : rlrx_pkg

// File: tb/rlrx_core_mdl.sv
// rlrx_core_mdl: register file and return stack beside the exec block.
// assumes a write lands at the address presented one cycle before file_we.
`timescale 1ns/100ps
module rlrx_core_mdl (
   input wire logic clock,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wdata,
   input wire logic file_we,
   input wire logic stack_pop,
   output logic [7:0] file_rdata,
   output logic [14:0] stack_top
);
   logic [7:0] mem [0:127];
   logic [14:0] stk [0:15];
   logic [3:0] sp;
   logic [6:0] addr_reg;
   // distinct preload so a wrong entry or address shows at once
   initial begin
      sp = 4'hf;
      for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
      for (int i = 0; i < 16; i++) stk[i] = 15'h1000 + 15'(i * 273);
   end
   assign file_rdata = mem[file_addr];
   assign stack_top = stk[sp];
   // write-back trails the accept, so the address is held one cycle
   always @(posedge clock) begin
      addr_reg <= file_addr;
      if (file_we) mem[addr_reg] <= file_wdata;
      if (stack_pop) sp <= sp - 4'h1;
   end
endmodule : rlrx_core_mdl

// File: tb/testbench.sv
// testbench: self-checking bench for rlrx_exec with expectation queue.
// assumes the core model above answers reads combinationally.
`timescale 1ns/100ps
module testbench;
   typedef struct packed {
      logic [7:0] w; logic c; logic we; logic [7:0] wd;
      logic [14:0] pc; logic [3:0] pulses;
   } rlrx_rec_t;
   logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1, insn_valid = 1'b0;
   logic [13:0] insn_word = 14'h0000;
   logic [7:0] file_rdata, file_wdata, w_out, ew, ecv;
   logic [14:0] stack_top, pc_out, epc;
   logic [6:0] file_addr;
   logic file_we, carry_out, pc_load, stack_pop, flush, busy, ec, tb_busy;
   logic [3:0] exp_sp;
   logic [7:0] shadow [0:127];
   int failures = 0, cmp_count = 0, cycles = 0;
   rlrx_rec_t q [$];
   rlrx_rec_t r;
   always #4 clock = ~clock;
   rlrx_exec dut_u (.clock(clock), .rst_b(rst_b), .clk_en(clk_en),
      .insn_valid(insn_valid), .insn_word(insn_word),
      .file_rdata(file_rdata), .stack_top(stack_top), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .w_out(w_out),
      .carry_out(carry_out), .pc_out(pc_out), .pc_load(pc_load),
      .stack_pop(stack_pop), .flush(flush), .busy(busy));
   rlrx_core_mdl mdl_u (.clock(clock), .file_addr(file_addr),
      .file_wdata(file_wdata), .file_we(file_we), .stack_pop(stack_pop),
      .file_rdata(file_rdata), .stack_top(stack_top));
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : summarize
   // one word per cycle; the expected outcome is noted before the edge
   task automatic drive(input logic vld, input logic [13:0] wd);
      logic [7:0] v, res;
      v = shadow[wd[6:0]];
      r = '0;
      // dead or frozen cycle ignores the word; a freeze keeps busy
      if (!clk_en || tb_busy || !vld) tb_busy = tb_busy && !clk_en;
      else if (wd[13:10] == 4'hd || wd == rlrx_pkg::OP_RETURN) begin
         if (wd[13:10] == 4'hd) ew = wd[7:0];
         epc = stack_top;
         r.pulses = 4'hf;
         tb_busy = 1'b1;
         exp_sp = exp_sp - 4'h1;
      end else if (wd[13:8] == rlrx_pkg::OP_ROTL ||
                   wd[13:8] == rlrx_pkg::OP_ROTR) begin
         res = (wd[13:8] == rlrx_pkg::OP_ROTL) ? {v[6:0], ec} : {ec, v[7:1]};
         ec = (wd[13:8] == rlrx_pkg::OP_ROTL) ? v[7] : v[0];
         if (wd[rlrx_pkg::DEST_BIT]) r.we = 1'b1;
         else ew = res;
         if (wd[rlrx_pkg::DEST_BIT]) shadow[wd[6:0]] = res;
         r.wd = wd[rlrx_pkg::DEST_BIT] ? res : 8'h00;
      end
      r.w = ew; r.c = ec; r.pc = epc;
      q.push_back(r);
      insn_valid = vld; insn_word = wd;
      @(posedge clock);
      #1;
   endtask : drive
   // results are checked half a nanosecond after the accepting edge
   always @(posedge clock) begin
      #0.5;
      if (q.size() > 0) begin
         rlrx_rec_t e;
         e = q.pop_front();
         check(w_out, e.w);
         check(carry_out, e.c);
         check({file_we, file_we ? file_wdata : 8'h00}, {e.we, e.wd});
         check(pc_out, e.pc);
         check({pc_load, stack_pop, flush, busy}, e.pulses);
      end
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         summarize();
      end
   end
   initial begin
      ew = rlrx_pkg::W_RESET; ec = rlrx_pkg::CARRY_RESET;
      epc = rlrx_pkg::PC_RESET; tb_busy = 1'b0; exp_sp = 4'hf;
      void'($urandom(48565));
      repeat (10) @(posedge clock);
      foreach (shadow[i]) shadow[i] = mdl_u.mem[i];
      #1 rst_b = 1'b1;
      // rotates back to back, random address, direction and destination
      for (int i = 0; i < 60; i++) begin
         ecv = 8'($urandom);
         drive(1'b1, {5'h06, ecv[0], ecv[1], 7'($urandom)});
      end
      // same byte written then read back to back
      drive(1'b1, 14'h0d85);
      drive(1'b1, 14'h0c05);
      drive(1'b1, 14'h0d7f);
      drive(1'b1, 14'h0c00);
      $display("rotate test done");
      // returns with a word offered in the dead cycle, literal extremes
      for (int i = 0; i < 12; i++) begin
         ecv = (i == 1) ? 8'h00 : (i == 3) ? 8'hff : 8'($urandom);
         drive(1'b1, i[0] ? {4'hd, 2'($urandom), ecv} :
            rlrx_pkg::OP_RETURN);
         drive(1'b1, {6'h0d, 8'($urandom)});
         drive(1'b1, 14'h0c85);
      end
      check(mdl_u.sp, exp_sp);
      $display("return test done");
      // unknown word and idle cycles leave all state alone
      drive(1'b1, 14'h0700);
      drive(1'b0, 14'h0d01);
      drive(1'b0, 14'h3455);
      // clock enable low drops the word and holds every output but file_addr, which follows insn_word
      clk_en = 1'b0;
      drive(1'b1, 14'h0d85);
      drive(1'b1, 14'h3412);
      clk_en = 1'b1;
      repeat (2) @(posedge clock);
      foreach (shadow[i]) check(mdl_u.mem[i], shadow[i]);
      $display("idle test done");
      summarize();
   end
endmodule : testbench
